// File: design/asf_pkg.sv
// asf_pkg: constants and types for the adaptive scaler filter datapath
// assumes: unsigned unit-range texels, signed fixed-point coefficients
`default_nettype none
package asf_pkg;
  // ----------------------------------------
  // widths and formats
  // ----------------------------------------
  localparam int TAPS = 8;
  localparam int TEX_W = 10;          // texel: unsigned fraction, 1.0 = 2**TEX_W
  localparam int COEF_W = 10;         // coefficient: signed, 1.0 = 2**COEF_FRAC
  localparam int COEF_FRAC = 8;
  localparam int FRAC_IN_W = 16;      // incoming fractional part
  localparam int FRAC_W = 5;          // truncated fraction
  localparam int MSB_W = 8;           // bits used by the adaptive weight
  localparam int PIPE_LAT = 3;        // cycles from accept to result
  localparam int FOOT_OFS = 3;        // footprint origin back-off
  localparam int CTR_LO = 3;          // centre row / column index
  localparam int CTR_HI = 4;
  localparam int NCH = 3;             // colour channels, green = index 1
  localparam int CH_G = 1;
  localparam int NTAB = 4;            // two tables per direction
  localparam int TAB_DEPTH = 32;
  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    ASF_FMT_RGB = 2'b00,
    ASF_FMT_YUV = 2'b01,
    ASF_FMT_OTHER = 2'b10
  } asf_fmt_t;
  localparam logic [1:0] TSEL_SHARED = 2'b00;
endpackage
`default_nettype wire

// File: design/asf_filter.sv
// asf_filter: sharp 8x8 separable filter, bilinear smooth filter, adaptive blend
// assumes: upstream supplies texels in row-major order, a coefficient load port,
//          and flushes the pipe before reloading coefficients
`default_nettype none
module asf_filter
  import asf_pkg::*;
#(
  parameter int TW = asf_pkg::TEX_W,
  parameter int CW = asf_pkg::COEF_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pixel request
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [NCH*TAPS*TAPS*TW-1:0] i_texels,
  input wire logic [FRAC_IN_W-1:0] i_frac_u,
  input wire logic [FRAC_IN_W-1:0] i_frac_v,
  input wire logic signed [15:0] i_coord_u_int,
  input wire logic signed [15:0] i_coord_v_int,
  input wire asf_pkg::asf_fmt_t i_format,
  input wire logic [1:0] i_table_sel,
  // coefficient load
  input wire logic i_coef_we,
  input wire logic [1:0] i_coef_table,
  input wire logic [FRAC_W-1:0] i_coef_index,
  input wire logic [TAPS*CW-1:0] i_coef_data,
  // result
  output logic o_valid,
  input wire logic i_ready,
  output logic [NCH*TW-1:0] o_color,
  output logic signed [15:0] o_foot_u,
  output logic signed [15:0] o_foot_v
);
  import asf_pkg::*;
  localparam int RW = TW + CW + 4;
  localparam int FW = RW + CW + 4;
  localparam logic [TW-1:0] ONE_MINUS = {TW{1'b1}};

  // ----------------------------------------
  // coefficient tables
  // ----------------------------------------
  logic [TAPS*CW-1:0] coef_mem [NTAB][TAB_DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_coef_we) begin
      coef_mem[i_coef_table][i_coef_index] <= i_coef_data;
    end
  end

  // ----------------------------------------
  // pipeline control
  // ----------------------------------------
  logic [PIPE_LAT-1:0] vld_reg, vld_next;
  logic adv;
  assign adv = !vld_reg[PIPE_LAT-1] || i_ready;
  assign o_ready = adv;
  assign o_valid = vld_reg[PIPE_LAT-1];
  always_comb begin
    vld_next = vld_reg;
    if (adv) begin
      vld_next = {vld_reg[PIPE_LAT-2:0], i_valid};
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= vld_next;
    end
  end

  // ----------------------------------------
  // stage 1: coefficient lookup and row filter
  // ----------------------------------------
  logic [FRAC_W-1:0] fu, fv;
  assign fu = i_frac_u[FRAC_IN_W-1 -: FRAC_W];
  assign fv = i_frac_v[FRAC_IN_W-1 -: FRAC_W];
  logic [TAPS*CW-1:0] kh_y, kh_c, kv_y, kv_c;
  always_comb begin
    kh_y = coef_mem[0][fu];
    kv_y = coef_mem[2][fv];
    kh_c = (i_table_sel == TSEL_SHARED) ? coef_mem[0][fu] : coef_mem[1][fu];
    kv_c = (i_table_sel == TSEL_SHARED) ? coef_mem[2][fv] : coef_mem[3][fv];
  end

  logic signed [RW-1:0] row_reg [NCH][TAPS];
  logic signed [RW-1:0] row_next [NCH][TAPS];
  logic [TAPS*CW-1:0] kv_reg [NCH];
  logic [TAPS*CW-1:0] kv_next [NCH];
  logic [TW-1:0] ctr_reg [NCH][4];
  logic [TW-1:0] ctr_next [NCH][4];
  logic [FRAC_W-1:0] fu_reg, fv_reg;
  logic [TW-1:0] luma_reg [TAPS];
  logic [TW-1:0] luma_next [TAPS];
  asf_fmt_t fmt_reg;
  logic signed [15:0] fu_int_reg, fv_int_reg;

  always_comb begin
    logic [TAPS*CW-1:0] kh;
    kh = '0;
    for (int c = 0; c < NCH; c++) begin
      kv_next[c] = (c == CH_G) ? kv_y : kv_c;
      kh = (c == CH_G) ? kh_y : kh_c;
      for (int r = 0; r < TAPS; r++) begin
        row_next[c][r] = '0;
        for (int k = 0; k < TAPS; k++) begin
          row_next[c][r] = row_next[c][r] + RW'(
            $signed({1'b0, i_texels[((c*TAPS+r)*TAPS+k)*TW +: TW]}) *
            $signed(kh[k*CW +: CW]));
        end
      end
      ctr_next[c][0] = i_texels[((c*TAPS+CTR_LO)*TAPS+CTR_LO)*TW +: TW];
      ctr_next[c][1] = i_texels[((c*TAPS+CTR_LO)*TAPS+CTR_HI)*TW +: TW];
      ctr_next[c][2] = i_texels[((c*TAPS+CTR_HI)*TAPS+CTR_LO)*TW +: TW];
      ctr_next[c][3] = i_texels[((c*TAPS+CTR_HI)*TAPS+CTR_HI)*TW +: TW];
    end
    // luma window: centre row of the green/luma plane
    for (int k = 0; k < TAPS; k++) begin
      luma_next[k] = i_texels[((CH_G*TAPS+CTR_LO)*TAPS+k)*TW +: TW];
    end
  end

  always_ff @(posedge i_clk) begin
    if (adv) begin
      row_reg <= row_next;
      kv_reg <= kv_next;
      ctr_reg <= ctr_next;
      luma_reg <= luma_next;
      fu_reg <= fu;
      fv_reg <= fv;
      fmt_reg <= i_format;
      fu_int_reg <= i_coord_u_int - 16'(FOOT_OFS);
      fv_int_reg <= i_coord_v_int - 16'(FOOT_OFS);
    end
  end

  // ----------------------------------------
  // stage 2: vertical filter, clamp, bilinear, weight
  // ----------------------------------------
  logic [TW-1:0] sharp_reg [NCH];
  logic [TW-1:0] sharp_next [NCH];
  logic [TW-1:0] smooth_reg [NCH];
  logic [TW-1:0] smooth_next [NCH];
  logic [MSB_W:0] alpha_reg, alpha_next;
  logic [1:0] fmt_ok_reg;
  logic signed [15:0] fu2_reg, fv2_reg;

  always_comb begin
    logic signed [FW-1:0] acc;
    logic [TW+FRAC_W:0] top, bot;
    logic [TW+2*FRAC_W+1:0] mix;
    logic [MSB_W-1:0] s8;
    logic [MSB_W-1:0] mx, mn;
    logic [MSB_W+1:0] avg;
    logic [MSB_W-1:0] span;
    acc = '0;
    top = '0;
    bot = '0;
    mix = '0;
    s8 = '0;
    mx = '0;
    mn = '1;
    avg = '0;
    for (int c = 0; c < NCH; c++) begin
      acc = '0;
      for (int r = 0; r < TAPS; r++) begin
        acc = acc + FW'(row_reg[c][r] * $signed(kv_reg[c][r*CW +: CW]));
      end
      acc = acc >>> (2 * COEF_FRAC);
      if (acc < 0) begin
        sharp_next[c] = '0;
      end else if (acc > FW'(ONE_MINUS)) begin
        sharp_next[c] = ONE_MINUS;
      end else begin
        sharp_next[c] = acc[TW-1:0];
      end
      // horizontal blend per centre row, then rows by vertical fraction
      top = (TW+FRAC_W+1)'(ctr_reg[c][0] * (6'd32 - fu_reg) + ctr_reg[c][1] * fu_reg);
      bot = (TW+FRAC_W+1)'(ctr_reg[c][2] * (6'd32 - fu_reg) + ctr_reg[c][3] * fu_reg);
      mix = (TW+2*FRAC_W+2)'(top * (6'd32 - fv_reg) + bot * fv_reg);
      smooth_next[c] = mix[2*FRAC_W +: TW];
      // weight source sample uses top bits only
      s8 = sharp_next[c][TW-1 -: MSB_W];
      avg = avg + ((c == CH_G) ? {1'b0, s8, 1'b0} : {2'b00, s8});
    end
    // ringing detector: spread of the eight luma samples
    for (int k = 0; k < TAPS; k++) begin
      s8 = luma_reg[k][TW-1 -: MSB_W];
      if (s8 > mx) begin
        mx = s8;
      end
      if (s8 < mn) begin
        mn = s8;
      end
    end
    span = mx - mn;
    // rgb contribution averages the spread with the weighted level
    if (fmt_reg == ASF_FMT_YUV) begin
      alpha_next = {1'b0, 8'hFF} - (MSB_W+1)'(span);
    end else begin
      alpha_next = {1'b0, 8'hFF} - (MSB_W+1)'((span + avg[MSB_W+1:2]) >> 1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (adv) begin
      sharp_reg <= sharp_next;
      smooth_reg <= smooth_next;
      alpha_reg <= alpha_next;
      fmt_ok_reg <= fmt_reg;
      fu2_reg <= fu_int_reg;
      fv2_reg <= fv_int_reg;
    end
  end

  // ----------------------------------------
  // stage 3: alpha blend
  // ----------------------------------------
  logic [NCH*TW-1:0] color_next;
  logic [TW+MSB_W+1:0] bl;
  always_comb begin
    bl = '0;
    for (int c = 0; c < NCH; c++) begin
      if (fmt_ok_reg == ASF_FMT_OTHER) begin
        color_next[c*TW +: TW] = sharp_reg[c];
      end else begin
        bl = (TW+MSB_W+2)'(sharp_reg[c] * alpha_reg +
          smooth_reg[c] * (9'h100 - alpha_reg));
        color_next[c*TW +: TW] = bl[MSB_W +: TW];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_color <= '0;
      o_foot_u <= '0;
      o_foot_v <= '0;
    end else if (adv) begin
      o_color <= color_next;
      o_foot_u <= fu2_reg;
      o_foot_v <= fv2_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_hold;
    @(posedge i_clk) disable iff (i_reset)
    o_valid && !i_ready |=> o_valid && $stable(o_color);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while stalled");

  property p_lat;
    @(posedge i_clk) disable iff (i_reset)
    i_valid && o_ready && i_ready [*3] |-> ##3 o_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("latency not three cycles");

  property p_clamp;
    @(posedge i_clk) disable iff (i_reset)
    vld_reg[1] |-> sharp_reg[0] <= ONE_MINUS && sharp_reg[2] <= ONE_MINUS;
  endproperty
  a_clamp: assert property (p_clamp) else $error("sharp out of range");

  property p_passthru;
    @(posedge i_clk) disable iff (i_reset)
    vld_reg[1] && adv && fmt_ok_reg == ASF_FMT_OTHER |=> o_color[TW-1:0] == $past(sharp_reg[0]);
  endproperty
  a_passthru: assert property (p_passthru) else $error("blend on other format");

  property p_foot;
    @(posedge i_clk) disable iff (i_reset)
    i_valid && adv ##1 adv ##1 adv |=> o_foot_u == $past(i_coord_u_int, 3) - 16'sd3;
  endproperty
  a_foot: assert property (p_foot) else $error("footprint origin wrong");

  property p_alpha;
    @(posedge i_clk) disable iff (i_reset)
    vld_reg[1] |-> alpha_reg <= 9'h0FF;
  endproperty
  a_alpha: assert property (p_alpha) else $error("blend weight out of range");
endmodule
`default_nettype wire

// File: testbench/asf_src.sv
// asf_src: upstream sampler model, drives pixel requests and coefficient loads
// assumes: called between edges, drives on the falling edge of i_clk
`default_nettype none
module asf_src
  import asf_pkg::*;
(
  // clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  // pixel request
  output logic o_valid,
  output logic [NCH*TAPS*TAPS*TEX_W-1:0] o_tex,
  output logic [FRAC_IN_W-1:0] o_fu,
  output logic [FRAC_IN_W-1:0] o_fv,
  output logic [15:0] o_cu,
  output logic [15:0] o_cv,
  output var asf_pkg::asf_fmt_t o_fmt,
  output logic [1:0] o_sel,
  // coefficient load
  output logic o_we,
  output logic [1:0] o_tab,
  output logic [FRAC_W-1:0] o_idx,
  output logic [TAPS*COEF_W-1:0] o_cd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_valid, o_tex, o_fu, o_fv, o_cu, o_cv, o_sel, o_we, o_tab, o_idx, o_cd} = '0;
    o_fmt = ASF_FMT_RGB;
  end
  // kind 0: one tap per index; 1: unit tap 3; 2: gain two; 3: negative
  task automatic load(input int kind);
    int tap;
    for (int t = 0; t < NTAB; t++) begin
      for (int i = 0; i < TAB_DEPTH; i++) begin
        @(negedge i_clk);
        tap = (t == 0) ? i % 8 : (t == 1) ? 7 - i % 8 : (t == 2) ? i / 4 : 7 - i / 4;
        o_we = 1'b1;
        o_tab = t[1:0];
        o_idx = i[4:0];
        o_cd = '0;
        if (kind == 0) o_cd[tap*COEF_W +: COEF_W] = 10'h100;
        else o_cd[3*COEF_W +: COEF_W] = (kind == 3 && t < 2) ? 10'h300 : 10'h100;
        if (kind == 2 && t < 2) o_cd[4*COEF_W +: COEF_W] = 10'h100;
      end
    end
    @(negedge i_clk);
    o_we = 1'b0;
    o_cd = ~o_cd;
  endtask
  task automatic send(input logic [NCH*TAPS*TAPS*TEX_W-1:0] tex, input logic [15:0] fu, fv,
                      cu, cv, input asf_fmt_t fmt, input logic [1:0] sel);
    @(negedge i_clk);
    o_valid = 1'b1;
    {o_tex, o_fu, o_fv, o_cu, o_cv, o_sel} = {tex, fu, fv, cu, cv, sel};
    o_fmt = fmt;
    do @(posedge i_clk); while (i_ready !== 1'b1);
  endtask
  // released texel, fraction and coordinate lines show a changed value; format and select keep the last one
  task automatic idle();
    @(negedge i_clk);
    o_valid = 1'b0;
    {o_tex, o_fu, o_fv, o_cu, o_cv} = ~{o_tex, o_fu, o_fv, o_cu, o_cv};
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// tb: self-checking bench for asf_filter with queued expectations
// assumes: asf_src drives the request side, bench drives downstream ready
`default_nettype none
module tb
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TXW = NCH * TAPS * TAPS * TEX_W;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic ds_ready = 1'b1;
  logic stall = 1'b0;
  logic s_valid, s_we, o_ready, o_valid;
  logic [TXW-1:0] s_tex;
  logic [15:0] s_fu, s_fv, s_cu, s_cv;
  logic [1:0] s_sel, s_tab;
  asf_fmt_t s_fmt;
  logic [4:0] s_idx;
  logic [79:0] s_cd;
  logic [29:0] o_color;
  logic signed [15:0] o_foot_u, o_foot_v;
  logic [61:0] exp_q[$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  asf_src src (.i_clk(i_clk), .i_ready(o_ready), .o_valid(s_valid), .o_tex(s_tex),
    .o_fu(s_fu), .o_fv(s_fv), .o_cu(s_cu), .o_cv(s_cv), .o_fmt(s_fmt), .o_sel(s_sel),
    .o_we(s_we), .o_tab(s_tab), .o_idx(s_idx), .o_cd(s_cd));
  asf_filter dut (.i_clk(i_clk), .i_reset(i_reset), .i_valid(s_valid), .o_ready(o_ready),
    .i_texels(s_tex), .i_frac_u(s_fu), .i_frac_v(s_fv), .i_coord_u_int(s_cu),
    .i_coord_v_int(s_cv), .i_format(s_fmt), .i_table_sel(s_sel), .i_coef_we(s_we),
    .i_coef_table(s_tab), .i_coef_index(s_idx), .i_coef_data(s_cd), .o_valid(o_valid),
    .i_ready(ds_ready), .o_color(o_color), .o_foot_u(o_foot_u), .o_foot_v(o_foot_v));
  always #5 i_clk = ~i_clk;
  always @(negedge i_clk) ds_ready <= stall ? ($urandom % 4 != 0) : 1'b1;
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    logic [61:0] e;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
    if (!i_reset && o_valid === 1'b1 && ds_ready === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : ~62'h0;
      check("color", o_color, e[61:32]);
      check("foot_u", $unsigned(o_foot_u), e[31:16]);
      check("foot_v", $unsigned(o_foot_v), e[15:0]);
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic go(input logic [TXW-1:0] tex, input logic [29:0] ex, input asf_fmt_t fmt,
                    input logic [15:0] fu, fv, input logic [1:0] sel);
    logic [15:0] cu, cv;
    cu = 16'($urandom_range(1999)) - 16'h3E8;
    cv = 16'($urandom_range(1999)) - 16'h3E8;
    exp_q.push_back({ex, cu - 16'h3, cv - 16'h3});
    src.send(tex, fu, fv, cu, cv, fmt, sel);
  endtask
  task automatic finish_test(input string name);
    int n;
    src.idle();
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(negedge i_clk);
      n++;
    end
    if (exp_q.size() != 0) n_fail++;
    $display("test %s done", name);
  endtask
  initial begin
    logic [TXW-1:0] tex;
    logic [29:0] v, ex;
    logic [15:0] fu, fv;
    logic [1:0] sel;
    int ht, vt, tp;
    void'($urandom(87589));
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    check("valid", o_valid, 32'h0);
    check("ready", o_ready, 32'h1);
    check("color", o_color, 32'h0);
    stall = 1'b1;
    src.load(0);
    for (int p = 0; p < 192; p++) tex[p*10 +: 10] = 10'(p * 5);
    for (int i = 0; i < 40; i++) begin
      fu = 16'($urandom);
      fv = 16'($urandom);
      sel = 2'($urandom);
      for (int c = 0; c < NCH; c++) begin
        ht = (sel == 0 || c == CH_G) ? fu[13:11] : 7 - fu[13:11];
        vt = (sel == 0 || c == CH_G) ? fv[15:13] : 7 - fv[15:13];
        ex[c*10 +: 10] = 10'((c * 64 + vt * 8 + ht) * 5);
      end
      go(tex, ex, ASF_FMT_OTHER, fu, fv, sel);
    end
    finish_test("tap_select");
    for (int k = 1; k < 4; k++) begin
      src.load(k);
      for (int i = 0; i < 24; i++) begin
        v = {10'($urandom), 10'($urandom), 10'($urandom)};
        for (int p = 0; p < 192; p++) tex[p*10 +: 10] = v[(p/64)*10 +: 10];
        for (int c = 0; c < NCH; c++) begin
          tp = 2 * v[c*10 +: 10];
          ex[c*10 +: 10] = (k == 3) ? 10'h0 : (tp > 1023) ? 10'h3FF : tp[9:0];
        end
        if (k == 1) go(tex, v, asf_fmt_t'(i % 3), 16'($urandom), 16'($urandom),
                       2'($urandom));
        else go(tex, ex, ASF_FMT_OTHER, 16'($urandom), 16'($urandom), 2'($urandom));
      end
      finish_test(k == 1 ? "uniform_blend" : "clamp");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
